// File: hw/pic_top.sv
`timescale 1ns/1ps
`default_nettype none

module pic_top (
  input  wire logic                           SYS_CLK,
  input  wire logic                           SYS_RST,
  input  wire logic [pic_pkg::ADDR_W-1:0]     AVS_ADDRESS,
  input  wire logic                           AVS_READ,
  input  wire logic                           AVS_WRITE,
  input  wire logic [pic_pkg::DATA_W-1:0]     AVS_WRITEDATA,
  input  wire logic [3:0]                     AVS_BYTEENABLE,
  output logic      [pic_pkg::DATA_W-1:0]     AVS_READDATA,
  output logic                                AVS_WAITREQUEST,
  output logic                                IRQ,
  input  wire logic [pic_pkg::NUM_SRC-1:0]    SRC_REQ,
  input  wire logic                           TWI_BYTE_SET,
  input  wire logic                           TWI_TIMEOUT_SET,
  output logic                                CPU_CALL_REQ,
  output logic      [pic_pkg::VEC_W-1:0]      CPU_VECTOR,
  output logic      [pic_pkg::LVL_W-1:0]      CPU_LEVEL,
  input  wire logic                           CPU_CALL_ACK,
  input  wire logic                           CPU_INT_RETURN,
  input  wire logic                           CPU_RET
);
  import pic_pkg::*;

  pic_state_t s_q;
  pic_state_t s_d;

  // gather the enable bit of each source from the two enable registers
  function automatic logic [NUM_SRC-1:0] en_map(input logic [REG_W-1:0] b, input logic [REG_W-1:0] e);
    logic [NUM_SRC-1:0] m;
    m             = '0;
    m[SRC_EXT0]   = b[0];
    m[SRC_TMR0]   = b[1];
    m[SRC_EXT1]   = b[2];
    m[SRC_TMR1]   = b[3];
    m[SRC_SER]    = b[4];
    m[SRC_BOD]    = b[5];
    m[SRC_ADC]    = b[6];
    m[SRC_TMR2]   = e[7];
    m[SRC_SPI]    = e[6];
    m[SRC_BRAKE]  = e[5];
    m[SRC_WDT]    = e[4];
    m[SRC_CAP]    = e[2];
    m[SRC_KEY]    = e[1];
    m[SRC_TWI]    = e[0];
    return m;
  endfunction

  // gather one select bank; basic and extended banks follow their own layouts
  function automatic logic [NUM_SRC-1:0] pr_map(input logic [REG_W-1:0] b, input logic [REG_W-1:0] e);
    logic [NUM_SRC-1:0] m;
    m             = '0;
    m[SRC_CAP]    = b[7];
    m[SRC_ADC]    = b[6];
    m[SRC_BOD]    = b[5];
    m[SRC_SER]    = b[4];
    m[SRC_TMR1]   = b[3];
    m[SRC_EXT1]   = b[2];
    m[SRC_TMR0]   = b[1];
    m[SRC_EXT0]   = b[0];
    m[SRC_TMR2]   = e[7];
    m[SRC_SPI]    = e[6];
    m[SRC_BRAKE]  = e[5];
    m[SRC_WDT]    = e[4];
    m[SRC_KEY]    = e[1];
    m[SRC_TWI]    = e[0];
    return m;
  endfunction

  // arbitration signals
  logic [NUM_SRC-1:0] req_vec;
  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] sel_lo;
  logic [NUM_SRC-1:0] sel_hi;
  logic [NUM_SRC-1:0] elig;
  logic               found;
  logic [LVL_W-1:0]   best_lvl;
  logic [SRC_W-1:0]   best_src;
  logic               busy;
  logic [LVL_W-1:0]   top_lvl;
  logic               win;

  // the two-wire request is the or of its request input and its sticky flags
  always_comb begin
    req_vec          = SRC_REQ;
    req_vec[SRC_TWI] = SRC_REQ[SRC_TWI] | (|s_q.twi_flags);
    en_vec           = en_map(s_q.basic_en, s_q.ext_en);
    sel_lo           = pr_map(s_q.prio_lo, s_q.eprio_lo);
    sel_hi           = pr_map(s_q.prio_hi, s_q.eprio_hi);
    elig             = req_vec & en_vec & {NUM_SRC{s_q.basic_en[BIT_GLOBAL_EN]}};
  end

  // scan in vector order; only a strictly higher level displaces the holder
  always_comb begin
    found    = 1'b0;
    best_lvl = '0;
    best_src = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (elig[i] && (!found || {sel_hi[i], sel_lo[i]} > best_lvl)) begin
        found    = 1'b1;
        best_lvl = {sel_hi[i], sel_lo[i]};
        best_src = SRC_W'(i);
      end
    end
  end

  // nested levels always climb, so the set of active levels is the stack
  always_comb begin
    busy    = |s_q.in_svc;
    top_lvl = '0;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (s_q.in_svc[l]) begin
        top_lvl = LVL_W'(l);
      end
    end
    win = found && (!busy || best_lvl > top_lvl);
  end

  // bus decode
  logic               bus_req;
  logic               take;
  logic               wr_ok;
  logic [REG_W-1:0]   wbyte;
  logic [REG_W-1:0]   rd_mux;

  assign bus_req = AVS_READ | AVS_WRITE;
  assign take    = bus_req & s_q.resp;
  assign wr_ok   = take & AVS_WRITE & AVS_BYTEENABLE[0];
  assign wbyte   = AVS_WRITEDATA[REG_W-1:0];

  // read mux; unmapped addresses read as zero
  always_comb begin
    case (AVS_ADDRESS)
      OFS_BASIC_EN:  rd_mux = s_q.basic_en;
      OFS_EXT_EN:    rd_mux = s_q.ext_en;
      OFS_PRIO_LO:   rd_mux = s_q.prio_lo;
      OFS_PRIO_HI:   rd_mux = s_q.prio_hi;
      OFS_EPRIO_LO:  rd_mux = s_q.eprio_lo;
      OFS_EPRIO_HI:  rd_mux = s_q.eprio_hi;
      OFS_EVT_STAT:  rd_mux = REG_W'(s_q.evt_stat);
      OFS_EVT_MASK:  rd_mux = REG_W'(s_q.evt_mask);
      OFS_IN_SVC:    rd_mux = REG_W'(s_q.in_svc);
      OFS_VEC_LO:    rd_mux = s_q.pend_vec[REG_W-1:0];
      OFS_VEC_HI:    rd_mux = s_q.pend_vec[VEC_W-1:REG_W];
      OFS_TWI_FLAGS: rd_mux = REG_W'(s_q.twi_flags);
      default:       rd_mux = REG_RST;
    endcase
  end

  // next state
  always_comb begin
    s_d = s_q;

    // one wait cycle per access: read data is captured while waitrequest is high
    s_d.resp = bus_req & ~s_q.resp;
    if (bus_req && !s_q.resp) begin
      s_d.rdata = rd_mux;
    end

    // register writes
    if (wr_ok) begin
      case (AVS_ADDRESS)
        OFS_BASIC_EN:  s_d.basic_en = wbyte;
        OFS_EXT_EN:    s_d.ext_en   = wbyte;
        OFS_PRIO_LO:   s_d.prio_lo  = wbyte;
        OFS_PRIO_HI:   s_d.prio_hi  = wbyte;
        OFS_EPRIO_LO:  s_d.eprio_lo = wbyte;
        OFS_EPRIO_HI:  s_d.eprio_hi = wbyte;
        OFS_EVT_MASK:  s_d.evt_mask = wbyte[EVT_W-1:0];
        OFS_TWI_FLAGS: s_d.twi_flags = s_q.twi_flags & ~wbyte[1:0];
        default:       s_d.basic_en = s_q.basic_en;
      endcase
    end

    // reading the event status clears it; new events set below and win
    if (take && AVS_READ && AVS_ADDRESS == OFS_EVT_STAT) begin
      s_d.evt_stat = '0;
    end

    // flag sets come after the software clear so a same-cycle event survives
    if (TWI_BYTE_SET) begin
      s_d.twi_flags[BIT_TWI_BYTE] = 1'b1;
    end
    if (TWI_TIMEOUT_SET) begin
      s_d.twi_flags[BIT_TWI_TIMEOUT] = 1'b1;
    end

    // acceptance: the core performs the long call, this block marks the level busy
    if (CPU_CALL_ACK && s_q.pend) begin
      s_d.in_svc[s_q.pend_lvl]  = 1'b1;
      s_d.evt_stat[EVT_ACCEPT] = 1'b1;
    end

    // only the interrupt return retires the top level; a plain return is ignored
    if (CPU_INT_RETURN && !CPU_RET) begin
      if (busy) begin
        s_d.in_svc[top_lvl]        = 1'b0;
        s_d.evt_stat[EVT_COMPLETE] = 1'b1;
      end else begin
        s_d.evt_stat[EVT_STRAY_RET] = 1'b1;
      end
    end

    // hold the call request low for a cycle after acceptance or return,
    // because the winner was computed from the old in-service state
    if ((CPU_CALL_ACK && s_q.pend) || CPU_INT_RETURN) begin
      s_d.pend = 1'b0;
    end else begin
      s_d.pend = win;
      if (win) begin
        s_d.pend_lvl = best_lvl;
        s_d.pend_src = best_src;
        s_d.pend_vec = VEC_TABLE[best_src];
      end
    end
  end

  // state register
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      s_q.basic_en  <= REG_RST;
      s_q.ext_en    <= REG_RST;
      s_q.prio_lo   <= REG_RST;
      s_q.prio_hi   <= REG_RST;
      s_q.eprio_lo  <= REG_RST;
      s_q.eprio_hi  <= REG_RST;
      s_q.evt_stat  <= '0;
      s_q.evt_mask  <= '0;
      s_q.twi_flags <= '0;
      s_q.in_svc    <= '0;
      s_q.pend      <= 1'b0;
      s_q.pend_lvl  <= '0;
      s_q.pend_src  <= '0;
      s_q.pend_vec  <= VEC_RST;
      s_q.resp      <= 1'b0;
      s_q.rdata     <= REG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign AVS_WAITREQUEST = bus_req & ~s_q.resp;
  assign AVS_READDATA    = {{(DATA_W-REG_W){1'b0}}, s_q.rdata};
  assign IRQ             = |(s_q.evt_stat & s_q.evt_mask);
  assign CPU_CALL_REQ    = s_q.pend;
  assign CPU_VECTOR      = s_q.pend_vec;
  assign CPU_LEVEL       = s_q.pend_lvl;

endmodule

`default_nettype wire

// File: pkg/pic_pkg.sv
package pic_pkg;

  // source count and widths
  localparam int unsigned NUM_SRC   = 14;
  localparam int unsigned SRC_W     = 4;
  localparam int unsigned LVL_W     = 2;
  localparam int unsigned NUM_LVL   = 4;
  localparam int unsigned VEC_W     = 16;
  localparam int unsigned REG_W     = 8;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned EVT_W     = 3;

  // source indices, ranked in ascending vector order
  localparam logic [SRC_W-1:0] SRC_EXT0  = 4'h0;
  localparam logic [SRC_W-1:0] SRC_TMR0  = 4'h1;
  localparam logic [SRC_W-1:0] SRC_EXT1  = 4'h2;
  localparam logic [SRC_W-1:0] SRC_TMR1  = 4'h3;
  localparam logic [SRC_W-1:0] SRC_SER   = 4'h4;
  localparam logic [SRC_W-1:0] SRC_TMR2  = 4'h5;
  localparam logic [SRC_W-1:0] SRC_TWI   = 4'h6;
  localparam logic [SRC_W-1:0] SRC_KEY   = 4'h7;
  localparam logic [SRC_W-1:0] SRC_BOD   = 4'h8;
  localparam logic [SRC_W-1:0] SRC_SPI   = 4'h9;
  localparam logic [SRC_W-1:0] SRC_WDT   = 4'hA;
  localparam logic [SRC_W-1:0] SRC_ADC   = 4'hB;
  localparam logic [SRC_W-1:0] SRC_CAP   = 4'hC;
  localparam logic [SRC_W-1:0] SRC_BRAKE = 4'hD;

  // vector addresses, entry n belongs to source n
  localparam logic [NUM_SRC-1:0][VEC_W-1:0] VEC_TABLE = {
    16'h0073, 16'h0063, 16'h005B, 16'h0053, 16'h004B, 16'h0043, 16'h003B,
    16'h0033, 16'h002B, 16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};

  // byte offsets on the register bus
  localparam logic [ADDR_W-1:0] OFS_BASIC_EN  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRIO_LO   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PRIO_HI   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EPRIO_LO  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EPRIO_HI  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IN_SVC    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_VEC_LO    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_VEC_HI    = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_TWI_FLAGS = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_EXT_EN    = 8'hE8;

  // field positions
  localparam int unsigned BIT_GLOBAL_EN   = 7;
  localparam int unsigned BIT_TWI_BYTE    = 0;
  localparam int unsigned BIT_TWI_TIMEOUT = 1;
  localparam int unsigned EVT_ACCEPT      = 0;
  localparam int unsigned EVT_COMPLETE    = 1;
  localparam int unsigned EVT_STRAY_RET   = 2;

  // reset values
  localparam logic [REG_W-1:0] REG_RST = 8'h00;
  localparam logic [VEC_W-1:0] VEC_RST = 16'h0000;

  typedef struct packed {
    logic [REG_W-1:0]   basic_en;
    logic [REG_W-1:0]   ext_en;
    logic [REG_W-1:0]   prio_lo;
    logic [REG_W-1:0]   prio_hi;
    logic [REG_W-1:0]   eprio_lo;
    logic [REG_W-1:0]   eprio_hi;
    logic [EVT_W-1:0]   evt_stat;
    logic [EVT_W-1:0]   evt_mask;
    logic [1:0]         twi_flags;
    logic [NUM_LVL-1:0] in_svc;
    logic               pend;
    logic [LVL_W-1:0]   pend_lvl;
    logic [SRC_W-1:0]   pend_src;
    logic [VEC_W-1:0]   pend_vec;
    logic               resp;
    logic [REG_W-1:0]   rdata;
  } pic_state_t;

endpackage

// File: test/pic_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module pic_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic [1:0] lag,
  output logic            ack
);
  logic [1:0] wait_q;

  // takes a pending call after lag idle cycles; one pulse per call, so a call is never taken twice
  always_ff @(posedge clk) begin
    if (rst || !req || ack) begin
      wait_q <= 2'h0;
      ack    <= 1'b0;
    end else if (wait_q == lag) begin
      ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule

`default_nettype wire

// File: test/pic_top_sva.sv
`timescale 1ns/1ps
`default_nettype none

module pic_sva (
  input wire logic        SYS_CLK,
  input wire logic        SYS_RST,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        IRQ,
  input wire logic        CPU_CALL_REQ,
  input wire logic [15:0] CPU_VECTOR,
  input wire logic [1:0]  CPU_LEVEL,
  input wire logic        CPU_CALL_ACK,
  input wire logic        CPU_INT_RETURN,
  input wire logic        CPU_RET
);
  logic [3:0] svc_q;
  logic [3:0] svc_d;
  logic [1:0] top;

  // mirror of the in-service levels, seen only from the core link
  always_comb begin
    svc_d = svc_q;
    top = 2'h0;
    for (int i = 0; i < 4; i++) if (svc_q[i]) top = i[1:0];
    if (CPU_CALL_REQ && CPU_CALL_ACK) svc_d[CPU_LEVEL] = 1'b1;
    else if (CPU_INT_RETURN && !CPU_RET) svc_d[top] = 1'b0;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) svc_q <= 4'h0;
    else svc_q <= svc_d;
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  wait_one_a: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("bus answer not after one wait cycle");
  idle_wait_a: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
    else $error("waitrequest while idle");
  data_upper_a: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  reset_quiet_a: assert property ($fell(SYS_RST) |-> !IRQ && !CPU_CALL_REQ && CPU_VECTOR == 16'h0000)
    else $error("outputs not quiet after reset");
  req_drop_a: assert property (CPU_CALL_REQ && CPU_CALL_ACK |=> !CPU_CALL_REQ)
    else $error("call request stays after acknowledge");
  vec_valid_a: assert property (CPU_CALL_REQ |-> CPU_VECTOR[2:0] == 3'h3 && CPU_VECTOR != 16'h006B
    && CPU_VECTOR >= 16'h0003 && CPU_VECTOR <= 16'h0073) else $error("vector outside table");
  pre_higher_a: assert property (CPU_CALL_REQ && svc_q != 4'h0 |-> CPU_LEVEL > top)
    else $error("preemption by level not above service");
  top_hold_a: assert property (svc_q[3] |-> !CPU_CALL_REQ)
    else $error("request while top level in service");
endmodule

bind pic_top pic_sva u_sva (.SYS_CLK, .SYS_RST, .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST, .IRQ,
  .CPU_CALL_REQ, .CPU_VECTOR, .CPU_LEVEL, .CPU_CALL_ACK, .CPU_INT_RETURN, .CPU_RET);

`default_nettype wire

// File: test/pic_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pic_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [13:0] src = 14'h0;
  logic [1:0]  fl = 2'h0;
  logic        iret_s = 1'b0;
  logic        ret = 1'b0;
  logic [1:0]  lag = 2'h0;
  logic [31:0] rdat;
  logic [15:0] cvec;
  logic [1:0]  clvl;
  logic        wt, irq, creq, ack;
  logic [7:0]  q;
  int          mismatches = 0;
  int          cmp_count = 0;

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  pic_top DUT (.SYS_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wt), .IRQ(irq),
    .SRC_REQ(src), .TWI_BYTE_SET(fl[0]), .TWI_TIMEOUT_SET(fl[1]), .CPU_CALL_REQ(creq),
    .CPU_VECTOR(cvec), .CPU_LEVEL(clvl), .CPU_CALL_ACK(ack), .CPU_INT_RETURN(iret_s), .CPU_RET(ret));

  pic_core_model core (.clk(clk), .rst(rst), .req(creq), .lag(lag), .ack(ack));

  task automatic close_out();
    $display("mismatches %0d, compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: saw %h, wanted %h", $time, g, e);
    end
  endtask

  // one access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= {24'h0, d};
    // waitrequest is settled mid-cycle; the following rising edge is the one that samples it low
    do @(negedge clk); while (wt !== 1'b0);
    @(posedge clk);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({8'h00, q}, {8'h00, e});
  endtask

  // vector sampled in the cycle before the core's taking edge
  task automatic take(input logic [15:0] v);
    do @(negedge clk); while (!(ack === 1'b1 && creq === 1'b1));
    chk(cvec, v);
  endtask

  task automatic drive(input logic [13:0] s);
    @(posedge clk);
    src <= s;
  endtask

  task automatic pulse(input logic r, input logic p, input logic [1:0] f);
    @(posedge clk);
    iret_s <= r;
    ret <= p;
    fl <= f;
    @(posedge clk);
    iret_s <= 1'b0;
    ret <= 1'b0;
    fl <= 2'h0;
  endtask

  // a refused request must not show even after a few cycles
  task automatic idle(input logic e);
    repeat (4) @(negedge clk);
    chk({15'h0, creq}, {15'h0, e});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a <= 44; a += 4) rdc(a[7:0], 8'h00);
    rdc(8'hE8, 8'h00);
    bus(1'b1, 8'h2C, 8'hFF);
    bus(1'b1, 8'h1C, 8'hFF);
    rdc(8'h2C, 8'h00);
    rdc(8'h1C, 8'h00);
    // each source alone, answered promptly and slowly
    bus(1'b1, 8'h00, 8'hFF);
    bus(1'b1, 8'hE8, 8'hFF);
    for (int i = 0; i < 14; i++) begin
      drive(14'h1 << i);
      lag <= i[1:0];
      take(16'h0003 + 16'(8 * (i + (i == 13))));
      drive(14'h0);
      pulse(1'b1, 1'b0, 2'h0);
    end
    // levels, preemption, nesting, ties
    bus(1'b1, 8'h04, 8'h88);
    bus(1'b1, 8'h08, 8'h90);
    drive(14'h0009);
    take(16'h001B);
    drive(14'h0001);
    idle(1'b0);
    drive(14'h1001);
    take(16'h0063);
    chk({14'h0, clvl}, 16'h0003);
    drive(14'h0011);
    rdc(8'h1C, 8'h0A);
    idle(1'b0);
    pulse(1'b0, 1'b1, 2'h0);
    idle(1'b0);
    pulse(1'b1, 1'b0, 2'h0);
    take(16'h0023);
    drive(14'h0001);
    pulse(1'b1, 1'b0, 2'h0);
    pulse(1'b1, 1'b0, 2'h0);
    take(16'h0003);
    drive(14'h0000);
    pulse(1'b1, 1'b0, 2'h0);
    drive(14'h0006);
    take(16'h000B);
    drive(14'h0004);
    pulse(1'b1, 1'b0, 2'h0);
    take(16'h0013);
    drive(14'h0000);
    pulse(1'b1, 1'b0, 2'h0);
    // status, mask and the interrupt line; last a stray return
    @(negedge clk);
    chk({15'h0, irq}, 16'h0);
    bus(1'b1, 8'h18, 8'h07);
    @(negedge clk);
    chk({15'h0, irq}, 16'h1);
    rdc(8'h14, 8'h03);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0);
    pulse(1'b1, 1'b0, 2'h0);
    @(negedge clk);
    chk({15'h0, irq}, 16'h1);
    rdc(8'h14, 8'h04);
    // two-wire flags, own enable and global enable
    bus(1'b1, 8'hE8, 8'h00);
    pulse(1'b0, 1'b0, 2'h1);
    idle(1'b0);
    rdc(8'h28, 8'h01);
    bus(1'b1, 8'hE8, 8'h01);
    take(16'h0033);
    rdc(8'h28, 8'h01);
    bus(1'b1, 8'h00, 8'h00);
    pulse(1'b1, 1'b0, 2'h2);
    idle(1'b0);
    rdc(8'h28, 8'h03);
    bus(1'b1, 8'h28, 8'h03);
    rdc(8'h28, 8'h00);
    close_out();
  end
endmodule

`default_nettype wire
